/* File: design/t2c_pkg.sv */
// Constants and types for the capture/reload timer block
package t2c_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] T2C_IDX_CONTROL  = 8'hc8;
    localparam logic [7:0] T2C_IDX_MODE     = 8'hc9;
    localparam logic [7:0] T2C_IDX_CAP_LOW  = 8'hca;
    localparam logic [7:0] T2C_IDX_CAP_HIGH = 8'hcb;
    localparam logic [7:0] T2C_IDX_CNT_LOW  = 8'hcc;
    localparam logic [7:0] T2C_IDX_CNT_HIGH = 8'hcd;
    localparam logic [7:0] T2C_IDX_IRQ_EN   = 8'hce;

    // Reset values and counter maximum
    localparam logic [7:0]  T2C_RST_BYTE  = 8'h00;
    localparam logic [15:0] T2C_RST_WORD  = 16'h0000;
    localparam logic [15:0] T2C_CNT_MAX   = 16'hffff;

    // Mode register field positions
    localparam int T2C_MODE_CAP_RESET = 3;
    localparam int T2C_MODE_CLK_OE    = 1;
    localparam int T2C_MODE_DOWN_EN   = 0;
    localparam logic [7:0] T2C_MODE_MASK = 8'h0b;

    // Interrupt enable register field
    localparam int T2C_IRQ_EN_BIT = 0;

    // Timing: system clock 20 ns, baud mode advances every 2 clocks
    localparam int T2C_CLK_PERIOD_NS = 20;
    localparam int T2C_BAUD_CLOCKS   = 2;
    localparam int T2C_TIMER_CLOCKS  = 4;
    localparam logic [1:0] T2C_BAUD_DIV_LAST = 2'(T2C_BAUD_CLOCKS - 1);
    localparam logic [1:0] T2C_TIMER_DIV_LAST = 2'(T2C_TIMER_CLOCKS - 1);

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic timer_overflow_flag;
        logic external_trigger_flag;
        logic rx_baud_source;
        logic tx_baud_source;
        logic trigger_enable;
        logic timer_run;
        logic counter_timer_select;
        logic capture_reload_select;
    } t2c_ctrl_s;

    localparam t2c_ctrl_s T2C_CTRL_RST = '0;
endpackage

/* File: design/t2c_fall_det.sv */
// Falling edge detector for a synchronous input pin
`timescale 1ns/100ps
`default_nettype none
module t2c_fall_det (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      fall
);
    logic prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= pin;
        end
    end

    assign fall = prev_r & ~pin;
endmodule
`default_nettype wire

/* File: design/t2c_timer.sv */
// Capture/reload timer with APB register access
`timescale 1ns/100ps
`default_nettype none
module t2c_timer
    import t2c_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_pin,
    input  wire logic        trigger_pin,
    input  wire logic        timer1_overflow,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             timer_irq,
    output logic             clock_out,
    output logic             clock_out_oe
);
    // ********************************
    // Register state
    // ********************************
    t2c_ctrl_s   ctrl_r;
    logic [7:0]  mode_r;
    logic [15:0] cap_r;
    logic [15:0] count_r;
    logic        irq_en_r;
    logic [1:0]  div_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        rx_tick_r;
    logic        tx_tick_r;
    logic        irq_r;
    logic        clk_out_r;
    logic        clk_oe_r;

    logic        baud_mode;
    logic        down_mode;
    logic        count_up;
    logic        tick;
    logic        trig_fall;
    logic        cnt_fall;
    logic        trig_act;
    logic        at_top;
    logic        at_bottom;
    logic        ovf;
    logic        reload;
    logic        capture;
    logic [15:0] count_nxt;
    logic        wr_en;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic        wr_ctrl;
    logic        wr_mode;
    logic        wr_cap_lo;
    logic        wr_cap_hi;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        wr_irq_en;

    // ********************************
    // Address decode functions
    // ********************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, T2C_IDX_CONTROL) | hit(a, T2C_IDX_MODE)
               | hit(a, T2C_IDX_CAP_LOW) | hit(a, T2C_IDX_CAP_HIGH)
               | hit(a, T2C_IDX_CNT_LOW) | hit(a, T2C_IDX_CNT_HIGH)
               | hit(a, T2C_IDX_IRQ_EN);
    endfunction

    // ********************************
    // Pin edge detection
    // ********************************
    t2c_fall_det u_trig_det (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (trigger_pin),
        .fall    (trig_fall)
    );

    t2c_fall_det u_cnt_det (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_count_pin),
        .fall    (cnt_fall)
    );

    // ********************************
    // APB index, write data and write enable decode
    // ********************************
    assign idx   = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel & penable & pready_r & pwrite & ~paddr[1] & ~paddr[0];

    // ********************************
    // Register write strobes, mode decode and tick generation
    // ********************************
    assign wr_ctrl   = wr_en & hit(idx, T2C_IDX_CONTROL);
    assign wr_mode   = wr_en & hit(idx, T2C_IDX_MODE);
    assign wr_cap_lo = wr_en & hit(idx, T2C_IDX_CAP_LOW);
    assign wr_cap_hi = wr_en & hit(idx, T2C_IDX_CAP_HIGH);
    assign wr_cnt_lo = wr_en & hit(idx, T2C_IDX_CNT_LOW);
    assign wr_cnt_hi = wr_en & hit(idx, T2C_IDX_CNT_HIGH);
    assign wr_irq_en = wr_en & hit(idx, T2C_IDX_IRQ_EN);

    assign baud_mode = ctrl_r.rx_baud_source | ctrl_r.tx_baud_source;
    assign down_mode = mode_r[T2C_MODE_DOWN_EN] & ~baud_mode
                     & ~ctrl_r.capture_reload_select;
    assign count_up  = ~down_mode | trigger_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 2'b00;
        end else if (baud_mode) begin
            div_r <= (div_r >= T2C_BAUD_DIV_LAST) ? 2'b00 : div_r + 2'b01;
        end else begin
            div_r <= (div_r >= T2C_TIMER_DIV_LAST) ? 2'b00 : div_r + 2'b01;
        end
    end

    always_comb begin
        if (!ctrl_r.timer_run) begin
            tick = 1'b0;
        end else if (baud_mode) begin
            tick = (div_r >= T2C_BAUD_DIV_LAST);
        end else if (ctrl_r.counter_timer_select) begin
            tick = cnt_fall;
        end else begin
            tick = (div_r >= T2C_TIMER_DIV_LAST);
        end
    end

    // ********************************
    // Count events
    // ********************************
    assign trig_act  = trig_fall & ctrl_r.trigger_enable & ~baud_mode
                     & ~down_mode;
    assign at_top    = (count_r == T2C_CNT_MAX);
    assign at_bottom = (count_r == cap_r);
    assign ovf       = tick & (count_up ? at_top : at_bottom);
    assign capture   = trig_act & ctrl_r.capture_reload_select;
    assign reload    = (ovf & count_up & (baud_mode
                        | ~ctrl_r.capture_reload_select))
                     | (trig_act & ~ctrl_r.capture_reload_select);

    always_comb begin
        count_nxt = count_r;
        if (reload) begin
            count_nxt = cap_r;
        end else if (capture && mode_r[T2C_MODE_CAP_RESET]) begin
            count_nxt = T2C_RST_WORD;
        end else if (ovf && !count_up) begin
            count_nxt = T2C_CNT_MAX;
        end else if (tick) begin
            count_nxt = count_up ? count_r + 16'h0001 : count_r - 16'h0001;
        end
    end

    // ********************************
    // Counter bytes
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= T2C_RST_WORD;
        end else begin
            count_r <= count_nxt;
            if (wr_cnt_lo) begin
                count_r[7:0] <= wbyte;
            end
            if (wr_cnt_hi) begin
                count_r[15:8] <= wbyte;
            end
        end
    end

    // ********************************
    // Capture/reload bytes
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r <= T2C_RST_WORD;
        end else if (capture) begin
            cap_r <= count_r;
        end else begin
            if (wr_cap_lo) begin
                cap_r[7:0] <= wbyte;
            end
            if (wr_cap_hi) begin
                cap_r[15:8] <= wbyte;
            end
        end
    end

    // ********************************
    // Control and mode registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= T2C_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= t2c_ctrl_s'(wbyte);
            end
            if (ovf && !baud_mode) begin
                ctrl_r.timer_overflow_flag <= 1'b1;
            end
            if (ovf && down_mode) begin
                ctrl_r.external_trigger_flag <= 1'b1;
            end
            if (trig_act) begin
                ctrl_r.external_trigger_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= T2C_RST_BYTE;
        end else if (wr_mode) begin
            mode_r <= wbyte & T2C_MODE_MASK;
        end
    end

    // ********************************
    // Interrupt enable register
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= 1'b0;
        end else if (wr_irq_en) begin
            irq_en_r <= wbyte[T2C_IRQ_EN_BIT];
        end
    end

    // ********************************
    // Interrupt, baud ticks and clock out
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_en_r & (ctrl_r.timer_overflow_flag
                   | ctrl_r.external_trigger_flag);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_tick_r <= 1'b0;
            tx_tick_r <= 1'b0;
        end else begin
            rx_tick_r <= ctrl_r.rx_baud_source ? ovf : timer1_overflow;
            tx_tick_r <= ctrl_r.tx_baud_source ? ovf : timer1_overflow;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_r <= 1'b0;
            clk_oe_r  <= 1'b0;
        end else begin
            clk_oe_r <= mode_r[T2C_MODE_CLK_OE];
            if (!mode_r[T2C_MODE_CLK_OE]) begin
                clk_out_r <= 1'b0;
            end else if (ovf) begin
                clk_out_r <= ~clk_out_r;
            end
        end
    end

    // ********************************
    // APB read path
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~mapped(idx);
            prdata_r  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (1'b1)
                    hit(idx, T2C_IDX_CONTROL):  prdata_r[7:0] <= ctrl_r;
                    hit(idx, T2C_IDX_MODE):     prdata_r[7:0] <= mode_r;
                    hit(idx, T2C_IDX_CAP_LOW):  prdata_r[7:0] <= cap_r[7:0];
                    hit(idx, T2C_IDX_CAP_HIGH): prdata_r[7:0] <= cap_r[15:8];
                    hit(idx, T2C_IDX_CNT_LOW):  prdata_r[7:0] <= count_r[7:0];
                    hit(idx, T2C_IDX_CNT_HIGH): prdata_r[7:0] <= count_r[15:8];
                    hit(idx, T2C_IDX_IRQ_EN):   prdata_r[0]   <= irq_en_r;
                    default:                    prdata_r      <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign rx_baud_tick = rx_tick_r;
    assign tx_baud_tick = tx_tick_r;
    assign timer_irq    = irq_r;
    assign clock_out    = clk_out_r;
    assign clock_out_oe = clk_oe_r;
endmodule
`default_nettype wire

/* File: test/t2c_pins_model.sv */
// Far-side pin model: count input and trigger input
`timescale 1ns/100ps
`default_nettype none
module t2c_pins_model (
    input  wire logic pclk,
    output logic      external_count_pin,
    output logic      trigger_pin
);
    // *********************************
    // Pins idle high, change after edge
    // *********************************
    initial begin
        external_count_pin = 1'h1;
        trigger_pin        = 1'h1;
    end
    task automatic count_edges(input int n);
        repeat (n) begin
            @(posedge pclk);
            external_count_pin <= 1'h0;
            repeat (3) @(posedge pclk);
            external_count_pin <= 1'h1;
            repeat (3) @(posedge pclk);
        end
    endtask
    task automatic trig(input logic v);
        @(posedge pclk);
        trigger_pin <= v;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: test/t2c_timer_asserts.sv */
// Port checker for the capture/reload timer
`timescale 1ns/100ps
`default_nettype none
module t2c_timer_asserts
    import t2c_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer1_overflow,
    input wire logic        rx_baud_tick,
    input wire logic        tx_baud_tick,
    input wire logic        timer_irq,
    input wire logic        clock_out,
    input wire logic        clock_out_oe
);
    // ****************
    // Register shadows
    // ****************
    logic [7:0] ctl_r;
    logic       irq_en_r;
    wire logic       wr  = psel && penable && pready && pwrite;
    wire logic [7:0] idx = paddr[9:2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r    <= 8'h0;
            irq_en_r <= 1'h0;
        end else begin
            if (wr && idx == T2C_IDX_CONTROL) ctl_r <= pwdata[7:0];
            if (wr && idx == T2C_IDX_IRQ_EN) irq_en_r <= pwdata[0];
        end
    end
    // **********
    // Properties
    // **********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_mode_wr;
        wr && idx == T2C_IDX_MODE;
    endsequence
    sequence s_flag_wr;
        wr && idx == T2C_IDX_CONTROL && pwdata[7:6] != 2'h0 && irq_en_r;
    endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_pair: assert property (pslverr |->
        pready && (pwrite || prdata == 0))
        else $error("error without ready or with data");
    a_err_unmapped: assert property (pready |-> pslverr == !(idx inside
        {[T2C_IDX_CONTROL:T2C_IDX_IRQ_EN]}))
        else $error("error flag wrong for index");
    a_read_upper: assert property (pready && !pwrite |->
        prdata[31:8] == 0) else $error("upper read bits set");
    a_oe_tracks: assert property (s_mode_wr |=> ##1
        clock_out_oe == $past(pwdata[1], 2)) else $error("oe not mode bit");
    a_clkout_idle: assert property (!clock_out_oe [*2] |-> !clock_out)
        else $error("clock out while disabled");
    a_rx_timer1: assert property (!ctl_r[5] && !$past(ctl_r[5]) |->
        rx_baud_tick == $past(timer1_overflow)) else $error("rx tick source");
    a_tx_timer1: assert property (!ctl_r[4] && !$past(ctl_r[4]) |->
        tx_baud_tick == $past(timer1_overflow)) else $error("tx tick source");
    a_irq_gated: assert property (!irq_en_r && !$past(irq_en_r) |->
        !timer_irq) else $error("irq while disabled");
    a_flag_irq: assert property (s_flag_wr |=> ##1 timer_irq)
        else $error("no irq after flag write");
endmodule
bind t2c_timer t2c_timer_asserts t2c_timer_asserts_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer1_overflow, .rx_baud_tick, .tx_baud_tick,
    .timer_irq, .clock_out, .clock_out_oe
);
`default_nettype wire

/* File: test/t2c_timer_tb.sv */
// Self-checking bench for the capture/reload timer
`timescale 1ns/100ps
`default_nettype none
module t2c_timer_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, q;
    logic        timer1_overflow, rx_baud_tick, tx_baud_tick, timer_irq;
    logic        clock_out, clock_out_oe, external_count_pin, trigger_pin;
    int          bad_count = 0, check_count = 0, nr = 0, nt = 0, nc = 0;
    t2c_timer t2c_timer_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_count_pin, .trigger_pin,
        .timer1_overflow, .rx_baud_tick, .tx_baud_tick, .timer_irq,
        .clock_out, .clock_out_oe
    );
    t2c_pins_model t2c_pins_model_i (.pclk, .external_count_pin, .trigger_pin);
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // *****
    // Tasks
    // *****
    task automatic chk(input string       w,
                       input logic [31:0] s,
                       input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic       w,
                       input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {22'h0, a, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            bad_count++;
            results();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        apb(1'h0, a, 8'h0);
        chk($sformatf("reg %h", a), q, {24'h0, x});
    endtask
    task automatic irq(input logic x);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, timer_irq}, {31'h0, x});
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        presetn = 1'h0;
        {psel, timer1_overflow} = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 8'hc8; i <= 8'hce; i++) rdc(8'(i), 8'h0);
        apb(1'h0, 8'hcf, 8'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        wr(8'hcc, 8'h5a);
        wr(8'hcd, 8'ha5);
        rdc(8'hcc, 8'h5a);
        rdc(8'hcd, 8'ha5);
        wr(8'hc8, 8'h01);
        t2c_pins_model_i.trig(1'h0);
        t2c_pins_model_i.trig(1'h1);
        rdc(8'hc8, 8'h01);
        rdc(8'hca, 8'h00);
        wr(8'hcc, 8'h0);
        wr(8'hcd, 8'h0);
        wr(8'hc9, 8'h08);
        wr(8'hc8, 8'h0f);
        t2c_pins_model_i.count_edges(5);
        rdc(8'hcc, 8'h05);
        t2c_pins_model_i.trig(1'h0);
        t2c_pins_model_i.trig(1'h1);
        rdc(8'hca, 8'h05);
        rdc(8'hcb, 8'h00);
        rdc(8'hcc, 8'h00);
        rdc(8'hc8, 8'h4f);
        wr(8'hce, 8'h01);
        irq(1'h1);
        wr(8'hc8, 8'h80);
        rdc(8'hc8, 8'h80);
        wr(8'hc8, 8'h00);
        irq(1'h0);
        wr(8'hc8, 8'h40);
        irq(1'h1);
        wr(8'hce, 8'h00);
        irq(1'h0);
        wr(8'hc9, 8'h00);
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        repeat (40) @(posedge pclk);
        rdc(8'hc8, 8'h84);
        wr(8'hc8, 8'h80);
        rdc(8'hcd, 8'h12);
        apb(1'h0, 8'hcc, 8'h0);
        repeat (20) @(posedge pclk);
        rdc(8'hcc, q[7:0]);
        wr(8'hc8, 8'h08);
        wr(8'hcc, 8'h0);
        wr(8'hcd, 8'h0);
        t2c_pins_model_i.trig(1'h0);
        t2c_pins_model_i.trig(1'h1);
        rdc(8'hcc, 8'h34);
        rdc(8'hcd, 8'h12);
        rdc(8'hc8, 8'h48);
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h01);
        wr(8'hca, 8'h0);
        wr(8'hcb, 8'h0);
        wr(8'hcc, 8'h03);
        wr(8'hcd, 8'h00);
        t2c_pins_model_i.trig(1'h0);
        wr(8'hc8, 8'h04);
        repeat (30) @(posedge pclk);
        rdc(8'hcd, 8'hff);
        rdc(8'hc8, 8'hc4);
        wr(8'hc8, 8'h00);
        t2c_pins_model_i.trig(1'h1);
        wr(8'hc9, 8'h02);
        wr(8'hca, 8'hfe);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h15);
        repeat (10) @(posedge pclk);
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            timer1_overflow <= (i % 8 == 0);
            nr += rx_baud_tick;
            nt += tx_baud_tick;
            nc += clock_out;
        end
        chk("clock out", nc, 32'h14);
        chk("tx ticks", nt, 32'ha);
        chk("rx ticks", nr, 32'h5);
        chk("clock oe", {31'h0, clock_out_oe}, 32'h1);
        rdc(8'hc8, 8'h15);
        results();
    end
endmodule
`default_nettype wire
